// [common/mra_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz core clock; included by the design file mra_regs_top, not by the package
`ifndef MRA_REGS_SVH
`define MRA_REGS_SVH

// -----------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------
`define MRA_ADDR_RANGE_LAT    8'h24
`define MRA_ADDR_ACCUM_CFG    8'h25
`define MRA_ADDR_ALERT_STAT   8'h26

// -----------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------
`define MRA_RST_RANGE_LAT     16'h0000
`define MRA_RST_ACCUM_CFG     8'h00
`define MRA_RST_ALERT_STAT    24'h000000

// -----------------------------------------------------------------------
// field positions (channel 1 lsb or bit, sense is channel 4; 2-bit fields step down by 2 per channel, alert bits by 1)
// -----------------------------------------------------------------------
`define MRA_SENSE_CH4_LSB     4'h8
`define MRA_BUS_CH1_LSB       4'h6
`define MRA_ACC_CH1_LSB       4'h6
`define MRA_OC_CH1_BIT        5'h17
`define MRA_UC_CH1_BIT        5'h13
`define MRA_OV_CH1_BIT        5'h0f
`define MRA_UV_CH1_BIT        5'h0b
`define MRA_OP_CH1_BIT        5'h07
`define MRA_ACC_FULL_BIT      5'h03
`define MRA_TALLY_FULL_BIT    5'h02
// bits 1-0 of alert status are unimplemented
`define MRA_ALERT_IMPL_MASK   24'hfffffc

// -----------------------------------------------------------------------
// timing: latched image valid after a snapshot
// -----------------------------------------------------------------------
`define MRA_CLK_MHZ           100
`define MRA_VALID_US          1000
`define MRA_VALID_CYCLES      (`MRA_VALID_US * `MRA_CLK_MHZ)

`endif

// [common/mra_pkg.sv]
// types shared by the range, accumulator and alert register block
// assumes mra_regs.svh for all numeric constants
package mra_pkg;

  // sense full-scale range selection
  typedef enum logic [1:0] {
    MRA_SENSE_UNI_100,
    MRA_SENSE_BI_100,
    MRA_SENSE_BI_50,
    MRA_SENSE_RSVD
  } mra_sense_fsr_t;

  // bus full-scale range selection
  typedef enum logic [1:0] {
    MRA_BUS_UNI_32,
    MRA_BUS_BI_32,
    MRA_BUS_BI_16,
    MRA_BUS_RSVD
  } mra_bus_fsr_t;

  // what each channel accumulator integrates
  typedef enum logic [1:0] {
    MRA_ACC_POWER,
    MRA_ACC_SHUNT,
    MRA_ACC_RAIL,
    MRA_ACC_RSVD
  } mra_acc_mode_t;

endpackage : mra_pkg

// [src/mra_regs_top.sv]
// range image, accumulator mode and alert cause registers
// assumes a byte-oriented serial slave on the same clock drives reg_*,
// and alert comparators deliver raw trip levels on the same clock
//
// How it works
// - ch4 sense range decodes unipolar, bipolar, fifty
// - ch1 bus range decodes 32V, bipolar, 16V
// - ch2-4 bus ranges at bits 5..0
// - accumulator modes per channel, reset zero
// - modes power, shunt, rail; reserved reads zero
// - alert status clears after read plus conversion
// - still-present condition keeps bit set
// - alert status updates live, no snapshot
// - alerts gated by alert_enable input bits, not reset here
// - bits 23-20 overcurrent channels one to four
// - bits 19-16 undercurrent channels one to four
// - bits 15-12 overvoltage, 11-8 undervoltage
// - bits 7-4 overpower channels one to four
// - bit3 integrator full, bit2 tally, 1-0 zero
// - range image latched at snapshot, valid later
`timescale 1ns/10ps
`include "mra_regs.svh"

module mra_regs_top #(
  parameter int VALID_CYCLES = `MRA_VALID_CYCLES
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // register port from the serial slave
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr_en,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_rd_start,
  output logic      [23:0]           reg_rdata,
  // measurement sequencing
  input  wire logic [15:0]           live_range_cfg,
  input  wire logic                  snapshot_pulse,
  input  wire logic                  conv_done,
  output logic                       range_image_valid,
  // alert sources and enables
  input  wire logic [3:0]            overcurrent_trip,
  input  wire logic [3:0]            undercurrent_trip,
  input  wire logic [3:0]            overvoltage_trip,
  input  wire logic [3:0]            undervoltage_trip,
  input  wire logic [3:0]            overpower_trip,
  input  wire logic                  integrator_full_trip,
  input  wire logic                  sample_tally_full_trip,
  input  wire logic [23:0]           alert_enable,
  // decoded settings
  output mra_pkg::mra_sense_fsr_t    sense_range_sel_ch4,
  output mra_pkg::mra_bus_fsr_t      bus_range_sel [4],
  output mra_pkg::mra_acc_mode_t     integrator_mode [4],
  output logic      [23:0]           alert_cause
);
  import mra_pkg::*;

  // -----------------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------------
  function automatic mra_bus_fsr_t bus_dec(input logic [1:0] f);
    case (f)
      2'h0:    bus_dec = MRA_BUS_UNI_32;
      2'h1:    bus_dec = MRA_BUS_BI_32;
      2'h2:    bus_dec = MRA_BUS_BI_16;
      default: bus_dec = MRA_BUS_RSVD;
    endcase
  endfunction : bus_dec

  // reserved code is never stored, so it cannot read back
  function automatic logic [1:0] acc_fix(input logic [1:0] f);
    acc_fix = (f == 2'h3) ? 2'h0 : f;
  endfunction : acc_fix

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  logic [15:0] range_lat;
  logic [15:0] next_range_lat;
  logic [7:0]  accum_cfg;
  logic [7:0]  next_accum_cfg;
  logic [23:0] alert_stat;
  logic [23:0] next_alert_stat;
  logic [23:0] read_snap;
  logic [23:0] next_read_snap;
  logic        clr_pend;
  logic        next_clr_pend;
  logic [23:0] next_reg_rdata;
  logic [31:0] valid_cnt;
  logic [31:0] next_valid_cnt;
  logic        next_valid;
  logic [23:0] trips;

  // -----------------------------------------------------------------------
  // trip word assembly
  // -----------------------------------------------------------------------
  always_comb begin
    trips = `MRA_RST_ALERT_STAT;
    for (int c = 0; c < 4; c++) begin
      trips[`MRA_OC_CH1_BIT - c] = overcurrent_trip[c];
      trips[`MRA_UC_CH1_BIT - c] = undercurrent_trip[c];
      trips[`MRA_OV_CH1_BIT - c] = overvoltage_trip[c];
      trips[`MRA_UV_CH1_BIT - c] = undervoltage_trip[c];
      trips[`MRA_OP_CH1_BIT - c] = overpower_trip[c];
    end
    trips[`MRA_ACC_FULL_BIT]   = integrator_full_trip;
    trips[`MRA_TALLY_FULL_BIT] = sample_tally_full_trip;
    // enables come straight from the alert_enable input; this block holds no enable register
    trips = trips & alert_enable & `MRA_ALERT_IMPL_MASK;
  end

  // -----------------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------------
  always_comb begin
    next_range_lat = range_lat;
    next_accum_cfg = accum_cfg;
    next_valid_cnt = valid_cnt;
    next_valid     = range_image_valid;
    if (snapshot_pulse) begin
      // image of the settings in force up to this snapshot
      next_range_lat = live_range_cfg;
    end else if (reg_wr_en && reg_addr == `MRA_ADDR_RANGE_LAT) begin
      next_range_lat = reg_wdata;
    end
    // a host write to the image must not stall the valid timer
    if (snapshot_pulse) begin
      next_valid_cnt = 32'(VALID_CYCLES);
      next_valid     = 1'b0;
    end else if (valid_cnt != 32'h0) begin
      next_valid_cnt = valid_cnt - 32'h1;
      next_valid     = (valid_cnt == 32'h1);
    end
    if (reg_wr_en && reg_addr == `MRA_ADDR_ACCUM_CFG) begin
      for (int c = 0; c < 4; c++) begin
        next_accum_cfg[2*c +: 2] = acc_fix(reg_wdata[2*c +: 2]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      range_lat         <= `MRA_RST_RANGE_LAT;
      accum_cfg         <= `MRA_RST_ACCUM_CFG;
      valid_cnt         <= 32'h0;
      range_image_valid <= 1'b0;
    end else begin
      range_lat         <= next_range_lat;
      accum_cfg         <= next_accum_cfg;
      valid_cnt         <= next_valid_cnt;
      range_image_valid <= next_valid;
    end
  end

  // -----------------------------------------------------------------------
  // decoded settings
  // -----------------------------------------------------------------------
  assign sense_range_sel_ch4 =
    mra_sense_fsr_t'(range_lat[`MRA_SENSE_CH4_LSB +: 2]);

  for (genvar c = 0; c < 4; c++) begin : g_ch
    assign bus_range_sel[c] =
      bus_dec(range_lat[`MRA_BUS_CH1_LSB - 2*c +: 2]);
    assign integrator_mode[c] =
      mra_acc_mode_t'(accum_cfg[`MRA_ACC_CH1_LSB - 2*c +: 2]);
  end

  // -----------------------------------------------------------------------
  // alert cause register
  // -----------------------------------------------------------------------
  // only bits that the host actually saw are cleared; anything newer or
  // still present survives, so a trip is never lost to a pending clear
  always_comb begin
    next_read_snap  = read_snap;
    next_clr_pend   = clr_pend;
    next_alert_stat = alert_stat | trips;
    if (reg_rd_start && reg_addr == `MRA_ADDR_ALERT_STAT) begin
      next_read_snap = alert_stat;
      next_clr_pend  = 1'b1;
    end else if (conv_done && clr_pend) begin
      next_alert_stat = (alert_stat & ~read_snap) | trips;
      next_clr_pend   = 1'b0;
    end
  end

  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd_start) begin
      case (reg_addr)
        `MRA_ADDR_RANGE_LAT:  next_reg_rdata = {8'h00, range_lat};
        `MRA_ADDR_ACCUM_CFG:  next_reg_rdata = {16'h0000, accum_cfg};
        `MRA_ADDR_ALERT_STAT: next_reg_rdata = alert_stat;
        default:              next_reg_rdata = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_stat <= `MRA_RST_ALERT_STAT;
      read_snap  <= `MRA_RST_ALERT_STAT;
      clr_pend   <= 1'b0;
    end else begin
      alert_stat <= next_alert_stat;
      read_snap  <= next_read_snap;
      clr_pend   <= next_clr_pend;
    end
  end

  // read data holds until the next read start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 24'h000000;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  assign alert_cause = alert_stat;

endmodule : mra_regs_top

// [sim/mra_host_model.sv]
// host model: register master toward the block's register port
// assumes one clock; every request launched just after a rising edge
`timescale 1ns/10ps
module mra_host_model (
  // clock
  input  wire logic        clk,
  // register port
  output logic      [7:0]  reg_addr,
  output logic             reg_wr_en,
  output logic      [15:0] reg_wdata,
  output logic             reg_rd_start,
  input  wire logic [23:0] reg_rdata
);
  initial begin
    reg_addr <= 8'h00;
    reg_wr_en <= 1'b0;
    reg_wdata <= 16'h0000;
    reg_rd_start <= 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    // released data flips so a stale value is never mistaken for a write
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_start <= 1'b1;
    @(posedge clk);
    reg_rd_start <= 1'b0;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : mra_host_model

// [sim/mra_regs_props.sv]
// assertions on the ports of the register block
// assumes it is bound into mra_regs_top
`timescale 1ns/10ps
module mra_regs_props
  import mra_pkg::*;
#(parameter int VALID_CYCLES = 20) (
  // clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // register port
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_rd_start,
  input wire logic [23:0]       reg_rdata,
  // sequencing
  input wire logic [15:0]       live_range_cfg,
  input wire logic              snapshot_pulse,
  input wire logic              conv_done,
  input wire logic              range_image_valid,
  // alerts
  input wire logic [3:0]        overcurrent_trip,
  input wire logic [3:0]        undercurrent_trip,
  input wire logic [3:0]        overpower_trip,
  input wire logic [23:0]       alert_enable,
  input wire logic [23:0]       alert_cause,
  // decodes
  input mra_pkg::mra_sense_fsr_t sense_range_sel_ch4,
  input mra_pkg::mra_bus_fsr_t   bus_range_sel [4],
  input mra_pkg::mra_acc_mode_t  integrator_mode [4]
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cycles since the last snapshot, held at the valid delay
  logic [31:0] since_snap;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      since_snap <= 32'h0;
    end else if (snapshot_pulse) begin
      since_snap <= 32'h1;
    end else if (since_snap != 32'h0 &&
                 since_snap < 32'(VALID_CYCLES)) begin
      since_snap <= since_snap + 32'h1;
    end
  end
  valid_early_a: assert property (range_image_valid
    |-> since_snap == 32'(VALID_CYCLES)) else $error("image valid early");
  valid_late_a: assert property (since_snap == 32'(VALID_CYCLES)
    && !snapshot_pulse |=> range_image_valid)
    else $error("image valid late");
  unused_bits_a: assert property (alert_cause[1:0] == 2'b00)
    else $error("alert bits 1-0 not zero");
  acc_read_a: assert property (reg_rd_start && reg_addr == 8'h25
    |=> reg_rdata == {16'h0, integrator_mode[0], integrator_mode[1],
      integrator_mode[2], integrator_mode[3]}) else $error("mode readback");
  oc_set_a: assert property (overcurrent_trip[0] && alert_enable[23]
    |=> alert_cause[23]) else $error("overcurrent bit not set");
  uc_cause_a: assert property ($rose(alert_cause[19])
    |-> $past(undercurrent_trip[0] & alert_enable[19]))
    else $error("undercurrent bit set without enabled trip");
  sticky_hold_a: assert property (alert_cause[23] && !conv_done
    |=> alert_cause[23]) else $error("alert bit cleared early");
  op_keep_a: assert property (conv_done && overpower_trip[0]
    && alert_enable[7] |=> alert_cause[7]) else $error("overpower lost");
  sense_image_a: assert property (snapshot_pulse |=> !range_image_valid
    && sense_range_sel_ch4 == $past(live_range_cfg[9:8]))
    else $error("sense range image");
  bus_image_a: assert property (snapshot_pulse
    |=> bus_range_sel[0] == $past(live_range_cfg[7:6]))
    else $error("bus range image");
  cover property (snapshot_pulse);
  cover property (conv_done && alert_cause[7]);
  cover property (reg_rd_start && reg_addr == 8'h26);
  cover property ($rose(range_image_valid));
endmodule : mra_regs_props
bind mra_regs_top mra_regs_props #(.VALID_CYCLES(VALID_CYCLES)) u_props (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_rd_start(reg_rd_start), .reg_rdata(reg_rdata),
  .live_range_cfg(live_range_cfg), .snapshot_pulse(snapshot_pulse),
  .conv_done(conv_done), .range_image_valid(range_image_valid),
  .overcurrent_trip(overcurrent_trip),
  .undercurrent_trip(undercurrent_trip),
  .overpower_trip(overpower_trip), .alert_enable(alert_enable),
  .alert_cause(alert_cause), .sense_range_sel_ch4(sense_range_sel_ch4),
  .bus_range_sel(bus_range_sel), .integrator_mode(integrator_mode));

// [sim/mra_regs_top_bench.sv]
// self-checking bench for the register block
// assumes the host model drives the register port
`timescale 1ns/10ps
module mra_regs_top_bench;
  import mra_pkg::*;
  localparam int VC = 20;
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic [7:0]    reg_addr;
  logic          reg_wr_en, reg_rd_start, range_image_valid;
  logic [15:0]   reg_wdata;
  logic [15:0]   live_range_cfg = 16'h0000;
  logic          snapshot_pulse = 1'b0, conv_done = 1'b0;
  logic [3:0]    oc = 4'h0, uc = 4'h0, ov = 4'h0, uv = 4'h0, op = 4'h0;
  logic          full = 1'b0, tally = 1'b0;
  logic [23:0]   en = 24'h0, reg_rdata, alert_cause;
  mra_sense_fsr_t sense_sel;
  mra_bus_fsr_t   bus_sel [4];
  mra_acc_mode_t  mode [4];
  int            err_count = 0;
  int            checks = 0;
  always #5 clk = ~clk;
  mra_host_model host (.clk(clk), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_start(reg_rd_start), .reg_rdata(reg_rdata));
  mra_regs_top #(.VALID_CYCLES(VC)) DUT (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_start(reg_rd_start), .reg_rdata(reg_rdata),
    .live_range_cfg(live_range_cfg), .snapshot_pulse(snapshot_pulse),
    .conv_done(conv_done), .range_image_valid(range_image_valid),
    .overcurrent_trip(oc), .undercurrent_trip(uc), .overvoltage_trip(ov),
    .undervoltage_trip(uv), .overpower_trip(op),
    .integrator_full_trip(full), .sample_tally_full_trip(tally),
    .alert_enable(en), .sense_range_sel_ch4(sense_sel),
    .bus_range_sel(bus_sel), .integrator_mode(mode),
    .alert_cause(alert_cause));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic conv;
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    tick(2);
  endtask : conv
  task automatic t_reset;
    logic [23:0] d;
    host.rd(8'h25, d);
    chk(d, 24'h0);
    host.rd(8'h26, d);
    chk(d, 24'h0);
    host.rd(8'h31, d);
    chk(d, 24'h0);
    $display("done reset");
  endtask : t_reset
  task automatic t_fields;
    logic [23:0] d;
    logic [1:0]  c, e;
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      e = (c == 2'h3) ? 2'h0 : c;
      host.wr(8'h24, {6'h2a, c, c, c, c, c});
      host.rd(8'h24, d);
      chk(d, {8'h0, 6'h2a, c, c, c, c, c});
      chk(24'(sense_sel), 24'(c));
      for (int i = 0; i < 4; i++) chk(24'(bus_sel[i]), 24'(c));
      host.wr(8'h25, {8'h0, c, c, c, c});
      host.rd(8'h25, d);
      chk(d, {16'h0, e, e, e, e});
      for (int i = 0; i < 4; i++) chk(24'(mode[i]), 24'(e));
    end
    $display("done fields");
  endtask : t_fields
  task automatic t_snap;
    logic [23:0] d;
    @(posedge clk);
    live_range_cfg <= 16'h01b4;
    snapshot_pulse <= 1'b1;
    @(posedge clk);
    snapshot_pulse <= 1'b0;
    #1;
    chk(24'(sense_sel), 24'h1);
    chk(24'(bus_sel[0]), 24'h2);
    tick(VC - 1);
    chk(24'(range_image_valid), 24'h0);
    tick(1);
    chk(24'(range_image_valid), 24'h1);
    host.rd(8'h24, d);
    chk(d, 24'h0001b4);
    $display("done snapshot");
  endtask : t_snap
  task automatic t_alert;
    logic [23:0] d;
    @(posedge clk);
    {oc, uc, ov, uv, op, full, tally} <= {20'h13591, 2'b11};
    tick(3);
    chk(alert_cause, 24'h0);
    @(posedge clk);
    en <= 24'hffffff;
    tick(3);
    chk(alert_cause, 24'h8ca98c);
    conv;
    chk(alert_cause, 24'h8ca98c);
    @(posedge clk);
    {oc, uc, ov, uv, full, tally} <= 18'h0;
    host.rd(8'h26, d);
    chk(d, 24'h8ca98c);
    conv;
    chk(alert_cause, 24'h000080);
    @(posedge clk);
    op <= 4'h0;
    host.rd(8'h26, d);
    chk(d, 24'h000080);
    @(posedge clk);
    uv <= 4'h1;
    @(posedge clk);
    uv <= 4'h0;
    conv;
    chk(alert_cause, 24'h000800);
    host.rd(8'h26, d);
    chk(d, 24'h000800);
    conv;
    chk(alert_cause, 24'h0);
    $display("done alert");
  endtask : t_alert
  task automatic t_midreset;
    logic [23:0] d;
    @(posedge clk);
    op <= 4'h2;
    host.wr(8'h25, 16'h0024);
    tick(1);
    chk(alert_cause, 24'h000040);
    chk(24'(mode[1]), 24'h2);
    @(posedge clk);
    sys_rst <= 1'b1;
    op <= 4'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(alert_cause, 24'h0);
    chk(reg_rdata, 24'h0);
    chk(24'(range_image_valid), 24'h0);
    chk(24'(mode[1]), 24'h0);
    host.rd(8'h24, d);
    chk(d, 24'h0);
    $display("done midreset");
  endtask : t_midreset
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_fields;
    t_snap;
    t_alert;
    t_midreset;
    finish_test;
  end
  // all tests need well under 1000 cycles
  initial begin
    #20000;
    err_count++;
    finish_test;
  end
endmodule : mra_regs_top_bench
